// file: dv/host_model.sv
// Register host model standing in for the serial framing side.
// Assumes reads are answered at the edge that takes them.
`timescale 1ns/1ps
module host_model
  import temp_sensor_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Request port
  output reg_req_t         req,
  input  wire logic [15:0] rd_data_q,
  input  wire logic        rd_valid_q
);
  initial req = '0;

  // One access; released fields are inverted so late sampling shows
  task automatic xfer(input logic ld, input logic [2:0] p,
                      input logic r, input logic w,
                      input logic [15:0] d, output logic [15:0] q);
    begin
      @(posedge clk);
      req <= '{cmd_ld: ld, ptr: p, rd: r, wr: w, wdata: d};
      @(posedge clk);
      req <= '{cmd_ld: 1'b0, ptr: ~p, rd: 1'b0, wr: 1'b0, wdata: ~d};
      #1;
      q = (r && rd_valid_q === 1'b1) ? rd_data_q : 16'hxxxx;
    end
  endtask

  // Nine-bit reading, dropping data bits 0 to 6
  function automatic logic [8:0] nine_bit(input logic [15:0] t);
    return t[15:7];
  endfunction
endmodule

// file: dv/tb_temp_sensor_regs.sv
// Self-checking bench of temp_sensor_regs driven through a host model.
// Assumes short conversion counts and a bench-driven converter code.
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
module tb_temp_sensor_regs
  import temp_sensor_pkg::*;
();
  localparam int unsigned CONV_T  = 20;
  localparam int unsigned FAST_T  = 5;
  localparam logic [7:0]  IDENT_T = 8'h5a; // Arbitrary value
  localparam int          LIMIT   = 6000;

  logic         clk;
  logic         rst;
  logic [15:0]  adc_code;
  reg_req_t     req;
  logic [15:0]  rd_data_q;
  logic         rd_valid_q;
  logic         conversion_ready_n;
  limit_flags_t flags_out_q;
  logic [15:0]  q;
  int           bad_count = 0;
  int           cmp_count = 0;
  int           cyc = 0;

  // Reset view, read-only places, conversion table (cfg, code, result)
  logic [15:0] rv [8] = '{16'h0080, 16'h0060, 16'h0000, {8'h00, IDENT_T},
                          16'h4980, 16'h0005, 16'h2000, 16'h0500};
  logic [2:0]  ro [3] = '{3'h0, 3'h2, 3'h3};
  logic [7:0]  cv_cfg [8] = '{8'h20, 8'h20, 8'h40, 8'h20, 8'hc0, 8'ha0,
                              8'h20, 8'h20};
  logic [15:0] cv_code [8] = '{16'h0c80, 16'h0900, 16'h0700, 16'hf380,
                               16'h0c85, 16'h8000, 16'h4a00, 16'h7ff8};
  logic [15:0] cv_temp [8] = '{16'h0c82, 16'h0902, 16'h0700, 16'hf381,
                               16'h0c85, 16'h8000, 16'h4a06, 16'h7ffe};
  logic [2:0]  cv_flag [8] = '{3'b010, 3'b010, 3'b000, 3'b001, 3'b010,
                               3'b001, 3'b110, 3'b110};

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  temp_sensor_regs #(
    .CONV_CYCLES (CONV_T),
    .FAST_CYCLES (FAST_T),
    .IDENT       (IDENT_T)
  ) dut_u (
    .clk                (clk),
    .rst                (rst),
    .req                (req),
    .rd_data_q          (rd_data_q),
    .rd_valid_q         (rd_valid_q),
    .adc_code           (adc_code),
    .conversion_ready_n (conversion_ready_n),
    .flags_out_q        (flags_out_q)
  );

  host_model host_u (
    .clk        (clk),
    .req        (req),
    .rd_data_q  (rd_data_q),
    .rd_valid_q (rd_valid_q)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic end_of_test();
    begin
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    logic [15:0] x;
    begin
      host_u.xfer(1'b1, p, 1'b0, 1'b1, d, x);
    end
  endtask

  task automatic rd(input logic [2:0] p, output logic [15:0] x);
    begin
      host_u.xfer(1'b1, p, 1'b1, 1'b0, 16'h0000, x);
    end
  endtask

  // Bounded wait for a stored result; the caller checks the outcome
  task automatic wait_conv();
    begin
      repeat (60)
        if (conversion_ready_n !== 1'b0)
        begin
          @(posedge clk);
          #1;
        end
    end
  endtask

  // Hang guard, counted as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    adc_code = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    host_u.xfer(1'b0, 3'h5, 1'b1, 1'b0, 16'h0000, q);
    check(q, 16'h0080);
    check({15'h0, conversion_ready_n}, 16'h0001);
    check({13'h0, flags_out_q}, 16'h0000);
    // Shutdown first, so no conversion disturbs the reset view
    wr(`REG_CONFIG, 16'h0060);
    for (int i = 1; i < 8; i++)
    begin
      rd(3'(i), q);
      check(q, rv[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(ro[i], 16'hffff);
      rd(ro[i], q);
      check(q, rv[ro[i]]);
    end
    wr(`REG_HYST, 16'hffff);
    rd(`REG_HYST, q);
    check(q, 16'h00ff);
    wr(`REG_HYST, 16'h0005);
    wr(`REG_HIGH, 16'h0a00);
    rd(`REG_HIGH, q);
    check(q, 16'h0a00);
    // One conversion per table row, in every one-shot flavour
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      adc_code <= cv_code[i];
      wr(`REG_CONFIG, {8'h00, cv_cfg[i]});
      wait_conv();
      check({15'h0, conversion_ready_n}, 16'h0000);
      @(posedge clk);
      #1;
      check({13'h0, flags_out_q}, {13'h0, cv_flag[i]});
      rd(`REG_TEMP, q);
      check(q, cv_temp[i]);
      check({15'h0, conversion_ready_n}, 16'h0001);
      if (i == 0)
        check({7'h00, host_u.nine_bit(q)}, 16'h0019);
    end
    rd(`REG_STATUS, q);
    check(q, 16'h00e0);
    rd(`REG_STATUS, q);
    check(q, 16'h0080);
    // Ready low is seen in status, then a one-shot write lifts it
    wr(`REG_CONFIG, 16'h0020);
    wait_conv();
    rd(`REG_STATUS, q);
    check(q, 16'h0060);
    wr(`REG_CONFIG, 16'h0020);
    check({15'h0, conversion_ready_n}, 16'h0001);
    // Continuous mode stores each result with no host action
    @(posedge clk);
    adc_code <= 16'h0c80;
    wr(`REG_CONFIG, 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      wait_conv();
      check({15'h0, conversion_ready_n}, 16'h0000);
      rd(`REG_TEMP, q);
      check(q, (i == 0) ? 16'h0c82 : 16'h0902);
      @(posedge clk);
      adc_code <= 16'h0900;
    end
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Pointer read before any command loads it again
    host_u.xfer(1'b0, 3'h6, 1'b1, 1'b0, 16'h0000, q);
    check(q, 16'h0080);
    rd(`REG_HIGH, q);
    check(q, 16'h2000);
    end_of_test();
  end
endmodule

// file: dv/temp_regs_monitor.sv
// Checker of the register port and ready bit of temp_sensor_regs.
// Assumes it sees the top module ports only; bound after endmodule.
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
module temp_regs_monitor
  import temp_sensor_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // Register port
  input wire reg_req_t     req,
  input wire logic [15:0]  rd_data_q,
  input wire logic         rd_valid_q,
  // Converter and status
  input wire logic [15:0]  adc_code,
  input wire logic         conversion_ready_n,
  input wire limit_flags_t flags_out_q
);
  // ****************************************
  // Pointer tracking
  // ****************************************
  logic [2:0] ptr_q;
  logic [2:0] rptr_q;
  logic [2:0] eff_ptr;

  // Pointer a request really uses
  assign eff_ptr = req.cmd_ld ? req.ptr : ptr_q;

  // Own copy of the pointer, so reads can be judged by target
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_q  <= `PTR_RST;
      rptr_q <= `PTR_RST;
    end
    else
    begin
      ptr_q <= eff_ptr;
      if (req.rd)
        rptr_q <= eff_ptr;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_valid_has_cause: assert property (rd_valid_q |-> $past(req.rd))
    else $error("read answer without a read");
  a_read_answered: assert property (req.rd |=> rd_valid_q)
    else $error("read not answered after one cycle");
  a_status_low_zero: assert property
    (rd_valid_q && rptr_q == `REG_STATUS |-> rd_data_q[3:0] == 4'h0)
    else $error("unused status bits not zero");
  a_byte_upper_zero: assert property
    (rd_valid_q && (rptr_q inside {`REG_STATUS, `REG_CONFIG, `REG_IDENT,
     `REG_HYST}) |-> rd_data_q[15:8] == 8'h00)
    else $error("byte register shows an upper byte");
  a_status_ready_view: assert property
    (rd_valid_q && rptr_q == `REG_STATUS |->
     rd_data_q[7] == $past(conversion_ready_n))
    else $error("status bit 7 differs from ready pin");
  a_oneshot_ready_set: assert property
    (req.wr && eff_ptr == `REG_CONFIG && (req.wdata[6:5] inside {2'h1, 2'h2})
     |=> conversion_ready_n)
    else $error("one-shot write left ready low");
  a_status_read_clears: assert property
    ((req.rd && eff_ptr == `REG_STATUS && conversion_ready_n)
     ##1 conversion_ready_n |-> flags_out_q == 3'b000)
    else $error("flags survive a status read");
  a_ready_low_holds: assert property
    (!conversion_ready_n && !(req.rd && eff_ptr == `REG_TEMP)
     && !(req.wr && eff_ptr == `REG_CONFIG) |=> !conversion_ready_n)
    else $error("ready went high without a result read");
endmodule

bind temp_sensor_regs temp_regs_monitor mon_u (
  .clk                (clk),
  .rst                (rst),
  .req                (req),
  .rd_data_q          (rd_data_q),
  .rd_valid_q         (rd_valid_q),
  .adc_code           (adc_code),
  .conversion_ready_n (conversion_ready_n),
  .flags_out_q        (flags_out_q)
);

// file: hdl/conv_timer.sv
// Conversion pacing: continuous, one-shot, fast one-shot, shutdown.
// Assumes a one-cycle start pulse on every configuration write.
`timescale 1ns/1ps
module conv_timer
  import temp_sensor_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = 2400000,
  parameter int unsigned FAST_CYCLES = 600000
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic [1:0] mode,
  input  wire logic       start,
  // Conversion finished
  output logic            done_q
);
  `include "temp_sensor_params.svh"

  conv_state_t state_q;
  logic [31:0] cnt_q;
  logic [31:0] last;

  // Fast mode trades accuracy for a quarter of the time
  assign last = (mode == `MODE_FAST) ? FAST_CYCLES - 32'd1
                                     : CONV_CYCLES - 32'd1;

  // Back to back in continuous mode, then idle after a one-shot
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= CONV_RUN;
      cnt_q   <= 32'h0;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        cnt_q   <= 32'h0;
        state_q <= (mode == `MODE_SHUTDOWN) ? CONV_IDLE : CONV_RUN;
      end
      else
      begin
        case (state_q)
          CONV_IDLE:
          begin
            cnt_q <= 32'h0;
          end
          CONV_RUN:
          begin
            if (cnt_q >= last)
            begin
              done_q  <= 1'b1;
              cnt_q   <= 32'h0;
              state_q <= (mode == `MODE_CONT) ? CONV_RUN : CONV_IDLE;
            end
            else
            begin
              cnt_q <= cnt_q + 32'h1;
            end
          end
          default:
          begin
            state_q <= CONV_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// file: hdl/limit_compare.sv
// Setpoint comparison with hysteresis for one temperature code.
// Assumes code and setpoints share the 16-bit scale of 128 codes per degree; hysteresis is in whole degrees.
`timescale 1ns/1ps
module limit_compare
  import temp_sensor_pkg::*;
(
  // Code and setpoints
  input  wire logic [15:0] code,
  input  wire logic [15:0] crit_sp,
  input  wire logic [15:0] high_sp,
  input  wire logic [15:0] low_sp,
  input  wire logic [7:0]  hyst,
  // Verdicts
  output limit_flags_t     set_flags,
  output limit_flags_t     clr_flags
);
  `include "temp_sensor_params.svh"

  // Sign extend so the hysteresis offset cannot wrap
  function automatic logic signed [17:0] widen(input logic [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  // Setpoint moved by whole degrees of hysteresis
  function automatic logic signed [17:0] shift_sp(input logic [15:0] sp,
                                                   input logic [7:0] h,
                                                   input logic up);
    logic signed [17:0] off;
    off = {3'h0, h, `CODE16_PER_DEG_LOG2'h0};
    return up ? widen(sp) + off : widen(sp) - off;
  endfunction

  logic signed [17:0] t;

  // Trip and release decisions
  always_comb
  begin
    t              = widen(code);
    set_flags.low  = t < widen(low_sp);
    set_flags.high = t > widen(high_sp);
    set_flags.crit = t > widen(crit_sp);
    clr_flags.low  = t > shift_sp(low_sp, hyst, 1'b1);
    clr_flags.high = t < shift_sp(high_sp, hyst, 1'b0);
    clr_flags.crit = t < shift_sp(crit_sp, hyst, 1'b0);
  end

endmodule

// file: hdl/temp_sensor_regs.sv
// Temperature result formatting, limit flags and the eight-register map.
// Assumes requests come from serial framing logic on the same clock and
// that the converter code arrives on pins from another domain.
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
module temp_sensor_regs
  import temp_sensor_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = 32'(`CONV_CYCLES),
  parameter int unsigned FAST_CYCLES = 32'(`FAST_CYCLES),
  parameter logic [7:0]  IDENT       = `IDENT_DEFAULT  // Arbitrary value
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register access from the serial framing logic
  input  wire reg_req_t    req,
  output logic [15:0]      rd_data_q,
  output logic             rd_valid_q,
  // Converter code, 128 codes per degree
  input  wire logic [15:0] adc_code,
  // Status view
  output logic             conversion_ready_n,
  output limit_flags_t     flags_out_q
);

  // ****************************************
  // Register state
  // ****************************************
  logic [2:0]   register_pointer_field_q;
  logic [7:0]   cfg_q;
  logic [15:0]  temp_q;
  logic [15:0]  crit_q;
  logic [7:0]   hyst_q;
  logic [15:0]  high_q;
  logic [15:0]  low_q;
  limit_flags_t flags_q;
  logic         ready_n_q;

  // ****************************************
  // Converter input synchroniser
  // ****************************************
  logic [15:0] adc_meta_q;
  logic [15:0] adc_sync_q;

  // Code changes only between conversions, so a plain two-stage pass is safe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      adc_meta_q <= 16'h0;
      adc_sync_q <= 16'h0;
    end
    else
    begin
      adc_meta_q <= adc_code;
      adc_sync_q <= adc_meta_q;
    end
  end

  // ****************************************
  // Access decode
  // ****************************************
  logic [2:0] addr;
  logic       status_rd;
  logic       temp_rd;
  logic       cfg_wr;
  logic       oneshot_wr;
  logic [1:0] new_mode;
  logic [1:0] cur_mode;
  logic       res16;

  // A command in the same cycle steers the access at once
  assign addr      = req.cmd_ld ? req.ptr : register_pointer_field_q;
  assign status_rd = req.rd && (addr == `REG_STATUS);
  assign temp_rd   = req.rd && (addr == `REG_TEMP);
  assign cfg_wr    = req.wr && (addr == `REG_CONFIG);
  assign new_mode  = req.wdata[`CFG_MODE_HI:`CFG_MODE_LO];
  assign cur_mode  = cfg_q[`CFG_MODE_HI:`CFG_MODE_LO];
  assign res16     = cfg_q[`CFG_RES_BIT];

  // Write of either one-shot pattern to the mode bits
  assign oneshot_wr = cfg_wr && ((new_mode == `MODE_ONESHOT) ||
                                 (new_mode == `MODE_FAST));

  // ****************************************
  // Conversion pacing
  // ****************************************
  logic       conv_done;
  logic [1:0] timer_mode;

  // Timer must see the mode being written, not the stale one
  assign timer_mode = cfg_wr ? new_mode : cur_mode;

  conv_timer #(
    .CONV_CYCLES (CONV_CYCLES),
    .FAST_CYCLES (FAST_CYCLES)
  ) u_timer (
    .clk    (clk),
    .rst    (rst),
    .mode   (timer_mode),
    .start  (cfg_wr),
    .done_q (conv_done)
  );

  // ****************************************
  // Result formatting and comparison
  // ****************************************
  logic [15:0]  code_fmt;
  logic [15:0]  crit_cmp;
  logic [15:0]  high_cmp;
  logic [15:0]  low_cmp;
  limit_flags_t set_flags;
  limit_flags_t clr_flags;
  limit_flags_t flags_d;
  logic [15:0]  temp_d;

  // Drops the three low bits when only 13 bits are resolved
  function automatic logic [15:0] trim(input logic [15:0] v,
                                       input logic wide);
    return wide ? v : {v[15:`RES_FLAG_BITS], `RES_FLAG_BITS'h0};
  endfunction

  // Step of 1/16 degC at 13 bits, 1/128 degC at 16 bits
  assign code_fmt = trim(adc_sync_q, res16);
  assign crit_cmp = trim(crit_q, res16);
  assign high_cmp = trim(high_q, res16);
  assign low_cmp  = trim(low_q, res16);

  limit_compare u_cmp (
    .code      (code_fmt),
    .crit_sp   (crit_cmp),
    .high_sp   (high_cmp),
    .low_sp    (low_cmp),
    .hyst      (hyst_q),
    .set_flags (set_flags),
    .clr_flags (clr_flags)
  );

  // Flags after this conversion, hysteresis release only on conversion
  always_comb
  begin
    flags_d = flags_q;
    if (status_rd)
    begin
      flags_d = '0;
    end
    if (conv_done)
    begin
      if (clr_flags.low)
      begin
        flags_d.low = 1'b0;
      end
      if (clr_flags.high)
      begin
        flags_d.high = 1'b0;
      end
      if (clr_flags.crit)
      begin
        flags_d.crit = 1'b0;
      end
      // Setting beats any clear arriving in the same cycle
      flags_d = flags_d | set_flags;
    end
  end

  // Flags ride in the low bits only at 13-bit resolution
  always_comb
  begin
    if (res16)
    begin
      temp_d = code_fmt;
    end
    else
    begin
      temp_d = {code_fmt[15:`RES_FLAG_BITS],
                flags_d.crit, flags_d.high, flags_d.low};
    end
  end

  // ****************************************
  // Result and flag registers
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      temp_q  <= `TEMP_RST;
      flags_q <= '0;
    end
    else
    begin
      if (conv_done)
      begin
        temp_q <= temp_d;
      end
      flags_q <= flags_d;
    end
  end

  // Ready is active low; a fresh result outranks a clearing access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ready_n_q <= `READY_N_RST;
    end
    else if (conv_done)
    begin
      ready_n_q <= 1'b0;
    end
    else if (temp_rd || oneshot_wr)
    begin
      ready_n_q <= 1'b1;
    end
  end

  // ****************************************
  // Pointer and writable registers
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      register_pointer_field_q <= `PTR_RST;
    end
    else if (req.cmd_ld)
    begin
      register_pointer_field_q <= req.ptr;
    end
  end

  // Result, status and ident have no write path
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q  <= `CONFIG_RST;
      crit_q <= `CRIT_RST;
      hyst_q <= `HYST_RST;
      high_q <= `HIGH_RST;
      low_q  <= `LOW_RST;
    end
    else if (req.wr)
    begin
      if (addr == `REG_CONFIG)
      begin
        cfg_q <= req.wdata[7:0];
      end
      else if (addr == `REG_CRIT)
      begin
        crit_q <= req.wdata;
      end
      else if (addr == `REG_HYST)
      begin
        hyst_q <= req.wdata[7:0];
      end
      else if (addr == `REG_HIGH)
      begin
        high_q <= req.wdata;
      end
      else if (addr == `REG_LOW)
      begin
        low_q <= req.wdata;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [15:0] rd_mux;

  // Eight-bit registers sit in the low byte, upper byte zero
  always_comb
  begin
    if (addr == `REG_STATUS)
    begin
      rd_mux = {8'h0, ready_n_q, flags_q.crit, flags_q.high,
                flags_q.low, 4'h0};
    end
    else if (addr == `REG_CONFIG)
    begin
      rd_mux = {8'h0, cfg_q};
    end
    else if (addr == `REG_TEMP)
    begin
      rd_mux = temp_q;
    end
    else if (addr == `REG_IDENT)
    begin
      rd_mux = {8'h0, IDENT};
    end
    else if (addr == `REG_CRIT)
    begin
      rd_mux = crit_q;
    end
    else if (addr == `REG_HYST)
    begin
      rd_mux = {8'h0, hyst_q};
    end
    else if (addr == `REG_HIGH)
    begin
      rd_mux = high_q;
    end
    else
    begin
      rd_mux = low_q;
    end
  end

  // Data holds until the next read so framing may shift it out slowly
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q  <= 16'h0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= req.rd;
      if (req.rd)
      begin
        rd_data_q <= rd_mux;
      end
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  assign conversion_ready_n = ready_n_q;

  // Registered copy of the limit flags for pin logic elsewhere
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_out_q <= '0;
    end
    else
    begin
      flags_out_q <= flags_d;
    end
  end

endmodule

// file: inc/temp_sensor_params.svh
// Constants of the temperature result, limit and status register block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TEMP_SENSOR_PARAMS_SVH
`define TEMP_SENSOR_PARAMS_SVH

// ****************************************
// Register pointer values
// ****************************************
`define REG_STATUS       3'h0
`define REG_CONFIG       3'h1
`define REG_TEMP         3'h2
`define REG_IDENT        3'h3
`define REG_CRIT         3'h4
`define REG_HYST         3'h5
`define REG_HIGH         3'h6
`define REG_LOW          3'h7
`define PTR_RST          3'h0

// ****************************************
// Reset values
// ****************************************
`define STATUS_RST       8'h80
`define READY_N_RST      1'b1
`define CONFIG_RST       8'h00
`define TEMP_RST         16'h0000
`define CRIT_RST         16'h4980
`define HYST_RST         8'h05
`define HIGH_RST         16'h2000
`define LOW_RST          16'h0500
`define IDENT_DEFAULT    8'h3c

// ****************************************
// Field positions
// ****************************************
`define CFG_RES_BIT      7
`define CFG_MODE_HI      6
`define CFG_MODE_LO      5
`define ST_READY_BIT     7
`define ST_CRIT_BIT      6
`define ST_HIGH_BIT      5
`define ST_LOW_BIT       4
`define RES_FLAG_BITS    3
`define MODE_CONT        2'h0
`define MODE_ONESHOT     2'h1
`define MODE_FAST        2'h2
`define MODE_SHUTDOWN    2'h3

// ****************************************
// Scaling and timing
// ****************************************
`define CODE16_PER_DEG_LOG2 7
`define CLK_HZ           64'd10000000
`define CONV_TIME_MS     64'd240
`define FAST_TIME_MS     64'd60
`define CONV_CYCLES      (`CONV_TIME_MS * `CLK_HZ / 64'd1000)
`define FAST_CYCLES      (`FAST_TIME_MS * `CLK_HZ / 64'd1000)

`endif

// file: inc/temp_sensor_pkg.sv
// Types shared by the temperature result and limit register block.
// Assumes nothing beyond a SystemVerilog compiler.
package temp_sensor_pkg;

  // ****************************************
  // Register access request from framing
  // ****************************************
  typedef struct packed {
    logic        cmd_ld;
    logic [2:0]  ptr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } reg_req_t;

  // ****************************************
  // Limit flags
  // ****************************************
  typedef struct packed {
    logic crit;
    logic high;
    logic low;
  } limit_flags_t;

  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;

endpackage
